// >>> pkg/pldp_pkg.sv
// Constants and types for the pin level data port
package pldp_pkg;
  localparam logic [7:0] PLDP_DATA_OFFSET = 8'hc4;
  localparam int PLDP_LO_PIN = 12;
  localparam int PLDP_HI_PIN = 18;
  localparam int PLDP_NPINS = 7;
  localparam int PLDP_PIN17 = 5;
  localparam int PLDP_PIN18 = 6;
  localparam int PLDP_NPORTS = 3;
  localparam int PLDP_LANE_BITS = 8;
  localparam logic [PLDP_NPINS-1:0] PLDP_DATA_RESET = 7'h00;
  localparam logic [1:0] PLDP_SEL_GPIN = 2'h0;
  localparam logic [1:0] PLDP_SEL_GPOUT = 2'h1;
  localparam logic [1:0] PLDP_SEL_ALT_A = 2'h2;
  localparam logic [1:0] PLDP_SEL_ALT_B = 2'h3;
  typedef enum logic [2:0] {
    PLDP_FN_GPIN,
    PLDP_FN_GPOUT,
    PLDP_FN_HP_INT,
    PLDP_FN_PRES_CHG,
    PLDP_FN_POWER_LIMIT_EXCEEDED_OUT,
    PLDP_FN_LED
  } pldp_fn_t;
endpackage : pldp_pkg

// >>> pkg/pldp_sync_if.sv
// Raw and synchronised pin levels between top and synchroniser
`timescale 1ns/1ps
interface pldp_sync_if;
  import pldp_pkg::*;
  logic [PLDP_NPINS-1:0] raw;
  logic [PLDP_NPINS-1:0] synced;
  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : pldp_sync_if

// >>> verilog/pldp_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module pldp_sync
  import pldp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  pldp_sync_if.sync sif
);
  logic [PLDP_NPINS-1:0] meta_r;
  logic [PLDP_NPINS-1:0] stable_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '0;
      stable_r <= '0;
    end
    else
    begin
      meta_r <= sif.raw;
      stable_r <= meta_r;
    end
  end

  assign sif.synced = stable_r;
endmodule : pldp_sync

// >>> verilog/pldp_port.sv
// Pin level data register, pins 12 to 18
`timescale 1ns/1ps
module pldp_port
  import pldp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic [31:0] cfg_rdata,
  input wire logic eeprom_load,
  input wire logic [PLDP_NPINS-1:0] eeprom_data,
  input wire logic [1:0] pin18_function_select,
  input wire logic [1:0] pin17_function_select,
  input wire logic [PLDP_NPINS-3:0] gp_out_sel,
  input wire logic pin13_led_sel,
  input wire logic pin12_led_sel,
  input wire logic pin13_led_level,
  input wire logic pin12_led_level,
  input wire logic hotplug_interrupt_req,
  input wire logic [PLDP_NPORTS-1:0] presence_detect_changed,
  input wire logic [PLDP_NPORTS-1:0] presence_change_enable,
  input wire logic perst_active,
  input wire logic power_limit_override,
  input wire logic slot_power_exceeded,
  input wire logic [PLDP_NPINS-1:0] pin_in,
  output logic [PLDP_NPINS-1:0] pin_out,
  output logic [PLDP_NPINS-1:0] pin_oe
);
  pldp_fn_t fn [PLDP_NPINS];
  logic [PLDP_NPINS-1:0] data_r;
  logic [PLDP_NPINS-1:0] gpout_mask;
  logic [PLDP_NPINS-1:0] drive_val;
  logic [PLDP_NPINS-1:0] drive_en;
  logic hit;
  logic rd_hit;
  logic wr_hit;
  logic [PLDP_NPINS-1:0] wr_mask;
  logic [PLDP_NPINS-1:0] wr_bits;
  logic pres_chg;
  logic power_limit_exceeded_out;
  pldp_sync_if sif ();

  function automatic pldp_fn_t pin18_decode(input logic [1:0] sel);
    unique case (sel)
      PLDP_SEL_GPIN: pin18_decode = PLDP_FN_GPIN;
      PLDP_SEL_GPOUT: pin18_decode = PLDP_FN_GPOUT;
      PLDP_SEL_ALT_A: pin18_decode = PLDP_FN_HP_INT;
      PLDP_SEL_ALT_B: pin18_decode = PLDP_FN_PRES_CHG;
    endcase
  endfunction : pin18_decode

  function automatic pldp_fn_t pin17_decode(input logic [1:0] sel);
    unique case (sel)
      PLDP_SEL_GPIN: pin17_decode = PLDP_FN_GPIN;
      PLDP_SEL_GPOUT: pin17_decode = PLDP_FN_GPOUT;
      PLDP_SEL_ALT_A: pin17_decode = PLDP_FN_GPIN;
      PLDP_SEL_ALT_B: pin17_decode = PLDP_FN_POWER_LIMIT_EXCEEDED_OUT;
    endcase
  endfunction : pin17_decode

  // Byte lane that carries a pin's data bit
  function automatic logic lane_enabled(input logic [3:0] be, input int pin);
    lane_enabled = be[(PLDP_LO_PIN + pin) / PLDP_LANE_BITS];
  endfunction : lane_enabled

  // Pins sit in their own field; every other bit of the word reads zero
  function automatic logic [31:0] place_pins(input logic [PLDP_NPINS-1:0] lv);
    place_pins = '0;
    place_pins[PLDP_HI_PIN:PLDP_LO_PIN] = lv;
  endfunction : place_pins

  // Write data bits that belong to pins
  function automatic logic [PLDP_NPINS-1:0] pick_pins(input logic [31:0] word);
    pick_pins = word[PLDP_HI_PIN:PLDP_LO_PIN];
  endfunction : pick_pins

  // Full byte offset compare; neighbouring registers must not alias here
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == PLDP_DATA_OFFSET);
  endfunction : addr_hit

  // Pins are asynchronous to the core clock; only the second flop reaches reads
  assign sif.raw = pin_in;

  pldp_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .sif(sif)
  );

  // Function per pin
  always_comb
  begin
    for (int i = 0; i < PLDP_PIN17; i++)
    begin
      fn[i] = gp_out_sel[i] ? PLDP_FN_GPOUT : PLDP_FN_GPIN;
    end
    if (pin12_led_sel)
      fn[0] = PLDP_FN_LED;
    if (pin13_led_sel)
      fn[1] = PLDP_FN_LED;
    fn[PLDP_PIN18] = pin18_decode(pin18_function_select);
    fn[PLDP_PIN17] = pin17_decode(pin17_function_select);
  end

  always_comb
  begin
    for (int i = 0; i < PLDP_NPINS; i++)
      gpout_mask[i] = (fn[i] == PLDP_FN_GPOUT);
  end

  assign pres_chg = |(presence_detect_changed & presence_change_enable);
  assign power_limit_exceeded_out = perst_active | (slot_power_exceeded & ~power_limit_override);

  // Pin drive values; alternate functions come from internal logic
  always_comb
  begin
    for (int i = 0; i < PLDP_NPINS; i++)
    begin
      drive_en[i] = (fn[i] != PLDP_FN_GPIN);
      drive_val[i] = data_r[i];
    end
    drive_val[0] = (fn[0] == PLDP_FN_LED) ? pin12_led_level : data_r[0];
    drive_val[1] = (fn[1] == PLDP_FN_LED) ? pin13_led_level : data_r[1];
    unique case (fn[PLDP_PIN18])
      PLDP_FN_HP_INT: drive_val[PLDP_PIN18] = hotplug_interrupt_req;
      PLDP_FN_PRES_CHG: drive_val[PLDP_PIN18] = pres_chg;
      default: drive_val[PLDP_PIN18] = data_r[PLDP_PIN18];
    endcase
    if (fn[PLDP_PIN17] == PLDP_FN_POWER_LIMIT_EXCEEDED_OUT)
      drive_val[PLDP_PIN17] = power_limit_exceeded_out;
  end

  assign hit = addr_hit(cfg_addr);
  assign rd_hit = cfg_rd && hit;
  assign wr_hit = cfg_wr && hit;
  assign wr_bits = pick_pins(cfg_wdata);

  always_comb
  begin
    for (int i = 0; i < PLDP_NPINS; i++)
      wr_mask[i] = gpout_mask[i] && lane_enabled(cfg_be, i);
  end

  // Data bits: only general outputs take writes; byte lanes 1 and 2 hold pins 12 to 18
  always_ff @(posedge clk or negedge arst_n)
  begin
    // reset then load
    // Preload beats a write in the same cycle, so software cannot race it
    if (!arst_n)
      data_r <= PLDP_DATA_RESET;
    else if (eeprom_load)
      data_r <= eeprom_data;
    else if (wr_hit)
    begin
      for (int i = 0; i < PLDP_NPINS; i++)
      begin
        if (wr_mask[i])
          data_r[i] <= wr_bits[i];
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      pin_out <= drive_val;
      pin_oe <= drive_en;
    end
  end

  // Reads show synced pin levels for every function, so writes to non-outputs never appear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_rdata <= '0;
    else if (rd_hit)
    begin
      cfg_rdata <= place_pins(sif.synced);
    end
    else
      cfg_rdata <= '0;
  end
endmodule : pldp_port

// >>> verification/pldp_chk.sv
// Checker on the pin level data port
`timescale 1ns/1ps
module pldp_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic [1:0] pin18_function_select,
  input wire logic [1:0] pin17_function_select,
  input wire logic [6:0] pin_in,
  input wire logic [6:0] pin_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_rd_idle: assert property (!$past(cfg_rd) |-> cfg_rdata == 32'h0) else $error("rdata not idle");
  a_rd_other: assert property ($past(cfg_rd) && $past(cfg_addr) != 8'hc4 |-> cfg_rdata == 32'h0)
    else $error("unmapped read");
  a_rsvd_zero: assert property (cfg_rdata[31:19] == 13'h0 && cfg_rdata[11:0] == 12'h0) else $error("rsvd");
  a_rd_level: assert property ($past(cfg_rd) && $past(cfg_addr) == 8'hc4 |-> cfg_rdata[18:12] == $past(pin_in, 3))
    else $error("not pin level");
  a_p17_in: assert property ($past(arst_n) && !$past(pin17_function_select[0]) |-> !pin_oe[5])
    else $error("pin17 on");
  a_p17_alt: assert property ($past(arst_n) && $past(pin17_function_select) == 2'h3 |-> pin_oe[5])
    else $error("pin17 off");
  a_p18_in: assert property ($past(arst_n) && $past(pin18_function_select) == 2'h0 |-> !pin_oe[6])
    else $error("pin18 on");
  a_p18_alt: assert property ($past(arst_n) && $past(pin18_function_select[1]) |-> pin_oe[6])
    else $error("pin18 off");
endmodule : pldp_chk

// >>> verification/pldp_board.sv
// Board model on the pins
`timescale 1ns/1ps
module pldp_board (
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic [6:0] ext,
  output logic [6:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : pldp_board

// >>> verification/tb.sv
// Bench for the pin level data port
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0, arst_n = 1'h0, cfg_wr = 1'h0, cfg_rd = 1'h0, eeprom_load = 1'h0, pin12_led_sel = 1'h0;
  logic perst_active = 1'h0, power_limit_override = 1'h0, slot_power_exceeded = 1'h0;
  wire logic pin12_led_level = pin12_led_sel, pin13_led_sel = pin12_led_sel, pin13_led_level = pin12_led_sel;
  wire logic hotplug_interrupt_req = perst_active;
  wire logic [2:0] presence_change_enable = {perst_active, 2'h3};
  logic [2:0] presence_detect_changed = 3'h4;
  logic [1:0] pin18_function_select = 2'h0, pin17_function_select = 2'h0;
  logic [7:0] cfg_addr = 8'hc4;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [3:0] cfg_be = 4'hf;
  logic [4:0] gp_out_sel = 5'h1f;
  logic [6:0] eeprom_data = 7'h0b, ext = 7'h7f, pin_in, pin_out, pin_oe;
  logic [31:0] rows [6] = '{32'h03e54015, 32'h015ff2ef, 32'h02003fef, 32'hffe00063, 32'hfbf80003, 32'ha7e01060};
  int errors = 0, n_tests = 0;
  pldp_port dut (.*);
  pldp_board board (.pin_out, .pin_oe, .ext, .pin_in);
  always #4 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Reserved bits set on every write so that dropping them is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [6:0] d);
    repeat (5) @(negedge clk);
    cfg_addr = a;
    cfg_wdata = {13'h1fff, d, 12'hfff};
    cfg_wr = w;
    cfg_rd = !w;
    @(negedge clk);
    cfg_wr = 1'h0;
    cfg_rd = 1'h0;
    if (!w)
      check(cfg_rdata, {13'h0, d, 12'h0});
  endtask : xfer
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (10) @(negedge clk);
    arst_n = 1'h1;
    xfer(1'h0, 8'hc4, 7'h60);
    eeprom_load = 1'h1;
    @(negedge clk);
    eeprom_load = 1'h0;
    xfer(1'h0, 8'hc4, 7'h6b);
    xfer(1'h1, 8'hc0, 7'h00);
    xfer(1'h0, 8'hc4, 7'h6b);
    xfer(1'h0, 8'hc0, 7'h00);
    $display("reset load address test done");
    foreach (rows[i])
    begin
      {pin18_function_select, pin17_function_select, pin12_led_sel, perst_active, gp_out_sel} = rows[i][31:21];
      ext = rows[i][13:7];
      xfer(1'h1, 8'hc4, rows[i][20:14]);
      xfer(1'h0, 8'hc4, rows[i][6:0]);
      $display("row %0d done", i);
    end
    perst_active = 1'h0;
    slot_power_exceeded = 1'h1;
    pin17_function_select = 2'h3;
    xfer(1'h0, 8'hc4, 7'h20);
    power_limit_override = 1'h1;
    xfer(1'h0, 8'hc4, 7'h00);
    $display("power limit test done");
    cfg_be = 4'h2;
    xfer(1'h1, 8'hc4, 7'h1f);
    cfg_be = 4'hf;
    xfer(1'h0, 8'hc4, 7'h0f);
    $display("byte lane test done");
    eeprom_data = 7'h15;
    eeprom_load = 1'h1;
    xfer(1'h1, 8'hc4, 7'h7f);
    eeprom_load = 1'h0;
    xfer(1'h0, 8'hc4, 7'h15);
    $display("preload collision test done");
    @(negedge clk);
    arst_n = 1'h0;
    @(negedge clk);
    check({25'h0, pin_oe}, 32'h0);
    check({25'h0, pin_out}, 32'h0);
    repeat (3) @(negedge clk);
    arst_n = 1'h1;
    xfer(1'h0, 8'hc4, 7'h00);
    check({25'h0, pin_oe}, 32'h7f);
    $display("second reset test done");
    print_verdict();
  end
endmodule : tb
bind pldp_port pldp_chk chk (.*);
